/* src/boot_mode_memory_map_select.sv */
// Top of the reset-time operating-mode capture and program map select block.
//
// Design decisions made here: the placing of the registers and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
module boot_mode_memory_map_select #(
  parameter bit REDUCED = 1'b0
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  input  wire logic        flashSecured,
  input  wire logic        coreDfReq,
  input  wire logic        secDfReq,
  output logic             coreDfGrant,
  output logic             secDfGrant,
  output logic             mapExternal,
  output logic             externalBoot,
  output logic             debugEnable,
  output logic             extProgAllowed,
  output logic [4:0]       extAddrLines,
  output logic [20:0]      resetVector,
  output logic [20:0]      watchdogResetVector,
  output logic             dataFlashPresent,
  output logic             progRamPresent
);
  import boot_mode_pkg::*;

  // ===========================================================
  // State
  // ===========================================================
  typedef struct packed {
    logic        mapSel;
    logic        secureSw;
    logic        secureRst;
    logic        widthRst;
    logic        external_boot_strap;
    logic        ack;
    logic [31:0] rdata;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // Straps are tied low in this package; kept as signals so the
  // decode below reads the same as on a fully pinned part.
  logic externalBootStrap;
  logic extMemWidthStrap;
  logic        hit;
  logic        wrStrobe;
  flash_port_t lastPort;

  assign externalBootStrap = STRAP_FIXED;
  assign extMemWidthStrap  = STRAP_FIXED;

  assign hit      = (wb_adr_i == ADR_MODE) || (wb_adr_i == ADR_STATUS) || (wb_adr_i == ADR_ARB);
  assign wrStrobe = wb_cyc_i && wb_stb_i && wb_we_i && !st_r.ack && hit && wb_sel_i[0];

  // ===========================================================
  // Next state
  // ===========================================================
  always_comb begin
    st_nxt     = st_r;
    st_nxt.ack = 1'b0;
    if (reset) begin
      // Sampled every cycle of reset, frozen at release.
      st_nxt.secureRst = !flashSecured;
      st_nxt.secureSw  = !flashSecured;
      // Secured flash forbids external boot: 01 becomes 00.
      st_nxt.mapSel    = externalBootStrap & !flashSecured;
      st_nxt.external_boot_strap   = externalBootStrap & !flashSecured;
      st_nxt.widthRst  = extMemWidthStrap;
      st_nxt.rdata     = '0;
    end else if (wb_cyc_i && wb_stb_i && !st_r.ack) begin
      st_nxt.ack   = 1'b1;
      st_nxt.rdata = '0;
      if (wrStrobe && (wb_adr_i == ADR_MODE)) begin
        st_nxt.mapSel   = wb_dat_i[BIT_MAP];
        // Stored for readback only; security and map ignore it.
        st_nxt.secureSw = wb_dat_i[BIT_SECURE];
      end
      if (!wb_we_i) begin
        case (wb_adr_i)
          ADR_MODE: begin
            st_nxt.rdata[BIT_MAP]    = st_r.mapSel;
            st_nxt.rdata[BIT_SECURE] = st_r.secureSw;
          end
          ADR_STATUS: begin
            st_nxt.rdata[STS_UNSEC]   = st_r.secureRst;
            st_nxt.rdata[STS_EXTERNAL_BOOT_STRAP] = st_r.external_boot_strap;
            st_nxt.rdata[STS_MAPEXT]  = mapExternal;
            st_nxt.rdata[STS_DEBUG]   = debugEnable;
            st_nxt.rdata[STS_DFLASH]  = dataFlashPresent;
            st_nxt.rdata[STS_PRAM]    = progRamPresent;
          end
          ADR_ARB: begin
            st_nxt.rdata[$bits(flash_port_t)-1:0] = lastPort;
          end
          default: begin
            st_nxt.rdata = '0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    st_r <= st_nxt;
  end

  // ===========================================================
  // Mode decode
  // ===========================================================
  // Map-select only counts when the flash was unsecured at reset.
  assign mapExternal    = st_r.mapSel & st_r.secureRst;
  assign externalBoot   = st_r.external_boot_strap;
  assign debugEnable    = st_r.secureRst;
  assign extProgAllowed = st_r.secureRst;
  assign extAddrLines   = (st_r.external_boot_strap && st_r.widthRst) ? WIDTH_20 : WIDTH_16;
  assign resetVector         = st_r.external_boot_strap ? EXT_BOOT_VEC : BOOT_VEC;
  assign watchdogResetVector = st_r.external_boot_strap ? EXT_WDOG_VEC : WDOG_VEC;

  // Program and data spaces are decoded separately; this block only
  // reports which optional stores exist.
  assign dataFlashPresent = !REDUCED;
  assign progRamPresent   = !REDUCED;

  // ===========================================================
  // Bus answer
  // ===========================================================
  assign wb_ack_o = st_r.ack;
  assign wb_err_o = 1'b0;
  assign wb_dat_o = st_r.rdata;

  dflash_read_arbiter u_arb (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .present   (dataFlashPresent),
    .coreReq   (coreDfReq),
    .secReq    (secDfReq),
    .coreGrant (coreDfGrant),
    .secGrant  (secDfGrant),
    .lastPort  (lastPort)
  );
endmodule
`default_nettype wire

/* pkg/boot_mode_pkg.sv */
// Package of constants and types for the boot-mode and program-map select block.
// What this block does
// - With secure-state 0 and map-select 0 at reset the chip boots internally in mode 0 with a 16-line external bus, no external program space and debug disabled.
// - Secure-state 0 with map-select 1 at reset is invalid and is configured exactly as if both bits were 0.
// - Secure-state 1 with map-select 1 at reset gives external boot mode 1, flash unsecured, with bus width from the width strap.
// - The secure-state bit is loaded only during reset and later security changes show only after the next reset.
// - Software writes to the secure-state bit never change the real flash security.
// - After reset software may write map-select and, if secure-state was 1 at reset, the new value changes the program map in use.
// - Writing the secure-state bit after reset has no effect on the program map.
// - The external-boot strap and the width strap are fixed at 0 in this package and cannot be changed.
// - Data flash may be read over the core read bus or the secondary read bus, never both in one cycle.
// - Program and data spaces are separate and independent, each with on-chip RAM and flash.
// - The reduced variant has no data flash and no program RAM, so accesses there reach no storage.
// - Map-select 0 picks the internal map and 1 the external map, and if secure-state was 0 at reset the bit has no effect.
// - In internal boot mode 0 the reset vector is at 04 0000 and the watchdog reset vector at 04 0002.
package boot_mode_pkg;
  localparam logic [3:0]  ADR_MODE     = 4'h0;
  localparam logic [3:0]  ADR_STATUS   = 4'h4;
  localparam logic [3:0]  ADR_ARB      = 4'h8;
  localparam int          BIT_MAP      = 0;
  localparam int          BIT_SECURE   = 1;
  localparam int          STS_UNSEC    = 0;
  localparam int          STS_EXTERNAL_BOOT_STRAP  = 1;
  localparam int          STS_MAPEXT   = 2;
  localparam int          STS_DEBUG    = 3;
  localparam int          STS_DFLASH   = 4;
  localparam int          STS_PRAM     = 5;
  localparam logic [20:0] BOOT_VEC     = 21'h04_0000;
  localparam logic [20:0] WDOG_VEC     = 21'h04_0002;
  localparam logic [20:0] EXT_BOOT_VEC = 21'h00_0000;
  localparam logic [20:0] EXT_WDOG_VEC = 21'h00_0002;
  localparam logic [4:0]  WIDTH_16     = 5'h10;
  localparam logic [4:0]  WIDTH_20     = 5'h14;
  localparam logic        STRAP_FIXED  = 1'b0;
  typedef enum logic [1:0] {PORT_NONE, PORT_CORE, PORT_SEC} flash_port_t;
endpackage

/* src/dflash_read_arbiter.sv */
// Data flash read arbiter between the core and secondary read buses.
`timescale 1ns/100ps
`default_nettype none
module dflash_read_arbiter (
  input  wire logic                       sys_clk,
  input  wire logic                       reset,
  input  wire logic                       present,
  input  wire logic                       coreReq,
  input  wire logic                       secReq,
  output logic                            coreGrant,
  output logic                            secGrant,
  output boot_mode_pkg::flash_port_t      lastPort
);
  import boot_mode_pkg::*;

  typedef struct packed {
    logic        preferSec;
    flash_port_t last;
  } arb_t;

  arb_t arb_r;
  arb_t arb_nxt;

  // Alternating priority keeps either bus from starving the other.
  always_comb begin
    arb_nxt   = arb_r;
    coreGrant = 1'b0;
    secGrant  = 1'b0;
    if (present) begin
      if (coreReq && (!secReq || !arb_r.preferSec)) begin
        coreGrant = 1'b1;
      end else if (secReq) begin
        secGrant = 1'b1;
      end
    end
    if (coreGrant) begin
      arb_nxt.preferSec = 1'b1;
      arb_nxt.last      = PORT_CORE;
    end else if (secGrant) begin
      arb_nxt.preferSec = 1'b0;
      arb_nxt.last      = PORT_SEC;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      arb_r <= '{preferSec: 1'b0, last: PORT_NONE};
    end else begin
      arb_r <= arb_nxt;
    end
  end

  assign lastPort = arb_r.last;
endmodule
`default_nettype wire

/* testbench/boot_mode_memory_map_select_checker.sv */
// Concurrent checks on the ports of the boot-mode and program-map block.
`timescale 1ns/100ps
`default_nettype none
module boot_mode_checker (
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic        wb_ack_o,
  input wire logic        coreDfGrant,
  input wire logic        secDfGrant,
  input wire logic        mapExternal,
  input wire logic        externalBoot,
  input wire logic        debugEnable,
  input wire logic        extProgAllowed,
  input wire logic [4:0]  extAddrLines,
  input wire logic [20:0] resetVector
);
  import boot_mode_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence reqTaken; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence modeWrite;
    wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == ADR_MODE && wb_sel_i[0];
  endsequence
  AST_ACK_NEXT: assert property (reqTaken |=> wb_ack_o) else $error("ack late");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  AST_GRANT_EXCL: assert property (!(coreDfGrant && secDfGrant)) else $error("double grant");
  AST_NO_EXT_BOOT: assert property (!externalBoot) else $error("ext boot");
  AST_WIDTH: assert property (extAddrLines == WIDTH_16) else $error("bus width");
  AST_VECTOR: assert property (resetVector == BOOT_VEC) else $error("reset vector");
  AST_MODE_HOLD: assert property (!$past(reset) |-> $stable(debugEnable)) else $error("mode moved");
  AST_SECURE_MAP: assert property (!debugEnable |-> !mapExternal) else $error("map when secured");
  AST_DBG_EXT: assert property (debugEnable == extProgAllowed) else $error("ext prog");
  AST_MAP_WRITE: assert property (modeWrite |=> mapExternal == ($past(wb_dat_i[BIT_MAP]) && debugEnable))
    else $error("map write");
endmodule
bind boot_mode_memory_map_select boot_mode_checker chk_u (.sys_clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_ack_o, .coreDfGrant, .secDfGrant, .mapExternal, .externalBoot,
  .debugEnable, .extProgAllowed, .extAddrLines, .resetVector);
`default_nettype wire

/* testbench/flash_core_model.sv */
// Model of the flash security logic and the two data-flash readers.
`timescale 1ns/100ps
`default_nettype none
module flash_core_model (
  input wire logic       sys_clk,
  input wire logic       secureCmd,
  input wire logic [1:0] reqCmd,
  output logic           flashSecured,
  output logic           coreDfReq,
  output logic           secDfReq
);
  // Security follows only its own command, never bus writes; flash is
  // altered only through the flash interface unit, never over this bus.
  always_ff @(posedge sys_clk) begin
    flashSecured <= secureCmd;
    {coreDfReq, secDfReq} <= reqCmd;
  end
endmodule
`default_nettype wire

/* testbench/boot_mode_memory_map_select_bench.sv */
// Self-checking bench for the boot-mode and program-map block.
`timescale 1ns/100ps
`default_nettype none
module boot_mode_memory_map_select_bench;
  import boot_mode_pkg::*;
  logic sys_clk = 0, reset = 1, we = 0, cyc = 0, stb = 0, ack, sec, secureCmd = 1;
  logic coreReq, secReq, coreG, secG, mapExt, external_boot_strap, dbg, extProg, dfPres, prPres;
  logic liteCoreG, liteSecG, liteDf, litePr, err;
  logic [3:0] adr = 0, sel = 0;
  logic [1:0] reqCmd = 0;
  logic [31:0] dat = 0, rdat, q;
  logic [4:0] lines;
  logic [20:0] rv, wv;
  int err_total = 0, samples_checked = 0, cycles = 0;
  initial forever #5 sys_clk = ~sys_clk;
  flash_core_model part_u (.sys_clk, .secureCmd, .reqCmd, .flashSecured(sec), .coreDfReq(coreReq),
    .secDfReq(secReq));
  boot_mode_memory_map_select dut_u (.sys_clk, .reset, .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
    .flashSecured(sec), .coreDfReq(coreReq), .secDfReq(secReq), .coreDfGrant(coreG), .secDfGrant(secG),
    .mapExternal(mapExt), .externalBoot(external_boot_strap), .debugEnable(dbg), .extProgAllowed(extProg),
    .extAddrLines(lines), .resetVector(rv), .watchdogResetVector(wv), .dataFlashPresent(dfPres),
    .progRamPresent(prPres));
  // Reduced variant on the same bus: only its storage flags and grants are compared.
  boot_mode_memory_map_select #(.REDUCED(1'b1)) lite_u (.sys_clk, .reset, .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(), .wb_ack_o(), .wb_err_o(),
    .flashSecured(sec), .coreDfReq(coreReq), .secDfReq(secReq), .coreDfGrant(liteCoreG), .secDfGrant(liteSecG),
    .mapExternal(), .externalBoot(), .debugEnable(), .extProgAllowed(), .extAddrLines(), .resetVector(),
    .watchdogResetVector(), .dataFlashPresent(liteDf), .progRamPresent(litePr));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wb(input logic [3:0] a, input logic [31:0] d, input logic w, input logic [3:0] s);
    @(posedge sys_clk);
    cyc <= 1; stb <= 1; adr <= a; dat <= d; we <= w; sel <= s;
    do @(posedge sys_clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 0; stb <= 0; we <= 0;
  endtask
  task automatic wrap_up;
    if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic do_reset(input logic s);
    @(posedge sys_clk);
    reset <= 1; secureCmd <= s;
    repeat (16) @(posedge sys_clk);
    reset <= 0;
  endtask
  always @(posedge sys_clk) if (++cycles == 3000) begin
    err_total++;
    wrap_up;
  end
  initial begin
    do_reset(1'b1);
    wb(ADR_STATUS, 32'h0, 1'b0, 4'hf); chk("status", 32'h30, q);
    chk("vectors", {11'h0, BOOT_VEC}, {11'h0, rv}); chk("wdog", {11'h0, WDOG_VEC}, {11'h0, wv});
    chk("lines", {27'h0, WIDTH_16}, {27'h0, lines}); chk("ext", 32'h0, {30'h0, external_boot_strap, extProg});
    wb(ADR_MODE, 32'h1, 1'b1, 4'hf); chk("map", 32'h0, {31'h0, mapExt});
    secureCmd <= 1'b0;
    wb(ADR_STATUS, 32'h0, 1'b0, 4'hf); chk("status", 32'h30, q);
    do_reset(1'b0);
    wb(ADR_MODE, 32'h0, 1'b0, 4'hf); chk("mode", 32'h2, q);
    wb(ADR_MODE, 32'h3, 1'b1, 4'hf); chk("map", 32'h1, {31'h0, mapExt});
    wb(ADR_STATUS, 32'h0, 1'b0, 4'hf); chk("status", 32'h3d, q);
    wb(ADR_MODE, 32'h1, 1'b1, 4'hf); chk("map", 32'h2, {30'h0, mapExt, sec});
    wb(ADR_MODE, 32'h0, 1'b1, 4'he); chk("map", 32'h1, {31'h0, mapExt});
    wb(4'hc, 32'h0, 1'b0, 4'hf); chk("unmapped", 32'h0, q); chk("err", 32'h0, {31'h0, err});
    reqCmd <= 2'b11;
    repeat (2) @(posedge sys_clk);
    chk("grants", 32'h2, {30'h0, coreG, secG});
    chk("lite", 32'h0, {28'h0, liteDf, litePr, liteCoreG, liteSecG});
    @(posedge sys_clk);
    chk("grants", 32'h1, {30'h0, coreG, secG});
    reqCmd <= 2'b00;
    wb(ADR_ARB, 32'h0, 1'b0, 4'hf); chk("last", {30'h0, PORT_CORE}, q);
    wrap_up;
  end
endmodule
`default_nettype wire
